// ### design/scrp_ctrl.sv
// sensor system control: serial register slave, pll divider decode, standby resets
module scrp_ctrl
    import scrp_pkg::*;
#(
    parameter logic [7:0] PART_HI = 8'h11, // arbitrary value
    parameter logic [7:0] PART_LO = 8'h22, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // arbitrary value
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // two-wire serial control bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oen_o,
    input wire logic addr_select_pin_i,
    // pin levels shown in status registers
    input wire logic [7:0] pin_status0_i,
    input wire logic [7:0] pin_status1_i,
    // run state and standby resets
    output logic streaming_o,
    output logic core_rst_n_o,
    output logic other_rst_n_o,
    // serial output configuration
    output logic [3:0] word_bits_o,
    output logic [3:0] lane_en_o,
    output logic hs_tx_powerdown_o,
    output logic lp_rx_powerdown_o,
    // pll a settings, fractional ratios in half steps
    output logic pll_a_skip_o,
    output logic [4:0] pll_a_input_prediv_x2_o,
    output logic [1:0] pll_a_extra_prediv_o,
    output logic [4:0] pll_a_post_div_o,
    output logic [9:0] pll_a_loop_mult_o,
    output logic [3:0] pll_a_serial_clk_div_o,
    output logic [2:0] pll_a_sys_prediv_o,
    output logic [1:0] pll_a_sys_div_o,
    // pll b settings, fractional ratios in half steps
    output logic pll_b_skip_o,
    output logic [4:0] pll_b_input_prediv_x2_o,
    output logic [1:0] pll_b_extra_prediv_o,
    output logic [3:0] pll_b_sys_div_x2_o,
    output logic [4:0] pll_b_sys_prediv_o,
    output logic [4:0] pll_b_ram_clk_div_o,
    output logic [4:0] pll_b_dac_clk_div_o,
    output logic [9:0] pll_b_loop_mult_o,
    // charge pump and clock source
    output logic [3:0] pump_n_div_o,
    output logic [3:0] pump_p_div_o,
    output logic pump_powerdown_o,
    output logic sysclk_from_b_o
);

    // ---------------------------------------------------------------
    // decode functions
    // ---------------------------------------------------------------
    // input pre-divider ratio times two
    function automatic logic [4:0] prediv_x2(input logic [2:0] code);
        logic [4:0] r;
        case (code)
            3'h0: r = 5'h02;
            3'h1: r = 5'h03;
            3'h2: r = 5'h04;
            3'h3: r = 5'h05;
            3'h4: r = 5'h06;
            3'h5: r = 5'h08;
            3'h6: r = 5'h0c;
            default: r = 5'h10;
        endcase
        return r;
    endfunction

    // charge pump divider ratio
    function automatic logic [3:0] pump_div(input logic [1:0] code);
        logic [3:0] r;
        case (code)
            2'h0: r = 4'h2;
            2'h1: r = 4'h3;
            2'h2: r = 4'h4;
            default: r = 4'h8;
        endcase
        return r;
    endfunction

    // ---------------------------------------------------------------
    // bus line sampling
    // ---------------------------------------------------------------
    logic scl_reg;
    logic sda_reg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else
        begin
            scl_reg <= scl_i;
            sda_reg <= sda_i;
        end
    end

    // edges and bus conditions
    assign scl_rise = scl_i & ~scl_reg;
    assign scl_fall = ~scl_i & scl_reg;
    assign bus_start = scl_i & scl_reg & sda_reg & ~sda_i;
    assign bus_stop = scl_i & scl_reg & ~sda_reg & sda_i;

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [7:0] cfg_reg [SCRP_NREG];
    logic wr_stb_reg;
    logic [15:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic soft_rst;

    // software reset restores every default
    assign soft_rst = wr_stb_reg && (wr_addr_reg == SCRP_A_SOFT_RST) && wr_data_reg[SCRP_B_SOFT_RST];

    genvar g;
    generate
        for (g = 0; g < SCRP_NREG; g++)
        begin : gen_reg
            always_ff @(posedge mclk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    cfg_reg[g] <= SCRP_RST[g];
                else if (soft_rst)
                    cfg_reg[g] <= SCRP_RST[g];
                else if (wr_stb_reg && wr_addr_reg == SCRP_ADDR[g])
                    cfg_reg[g] <= wr_data_reg;
            end
        end
    endgenerate

    // read data for the current pointer
    logic [15:0] ptr_reg;
    logic [7:0] rd_map;
    logic [7:0] rd_data;

    always_comb
    begin
        rd_map = 8'h00;
        for (int i = 0; i < SCRP_NREG; i++)
            if (ptr_reg == SCRP_ADDR[i])
                rd_map = cfg_reg[i];
    end

    assign rd_data = (ptr_reg == SCRP_A_PART_HI) ? PART_HI :
                     (ptr_reg == SCRP_A_PART_LO) ? PART_LO :
                     (ptr_reg == SCRP_A_REV) ? REVISION :
                     (ptr_reg == SCRP_A_PIN0) ? pin_status0_i :
                     (ptr_reg == SCRP_A_PIN1) ? pin_status1_i : rd_map;

    // ---------------------------------------------------------------
    // serial bus slave
    // ---------------------------------------------------------------
    scrp_state_t state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] phase_reg;
    logic read_reg;
    logic drive_reg;
    logic nack_reg;
    logic [7:0] dev_addr;
    logic addr_match;

    // write address chosen by the select pin
    assign dev_addr = addr_select_pin_i ? SCRP_DEV_ALT : cfg_reg[SCRP_I_BUS_ADDR];
    assign addr_match = shift_reg[7:1] == dev_addr[7:1];

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= SCRP_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            phase_reg <= 2'h0;
            read_reg <= 1'b0;
            drive_reg <= 1'b0;
            nack_reg <= 1'b0;
            ptr_reg <= 16'h0000;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
            wr_data_reg <= 8'h00;
        end
        else
        begin
            wr_stb_reg <= 1'b0;
            if (bus_start)
            begin
                state_reg <= SCRP_RX;
                bit_cnt_reg <= 4'h0;
                phase_reg <= 2'h0;
                drive_reg <= 1'b0;
            end
            else if (bus_stop)
            begin
                state_reg <= SCRP_IDLE;
                drive_reg <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    SCRP_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg <= {shift_reg[6:0], sda_i};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_reg == 4'h8)
                        begin
                            state_reg <= SCRP_ACK;
                            drive_reg <= 1'b1;
                            case (phase_reg)
                                2'h0:
                                begin
                                    read_reg <= shift_reg[0];
                                    if (!addr_match)
                                    begin
                                        state_reg <= SCRP_IDLE;
                                        drive_reg <= 1'b0;
                                    end
                                end
                                2'h1: ptr_reg[15:8] <= shift_reg;
                                2'h2: ptr_reg[7:0] <= shift_reg;
                                default:
                                begin
                                    wr_stb_reg <= 1'b1;
                                    wr_addr_reg <= ptr_reg;
                                    wr_data_reg <= shift_reg;
                                    ptr_reg <= ptr_reg + 16'h0001;
                                end
                            endcase
                        end
                    end
                    SCRP_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt_reg <= 4'h0;
                            if (read_reg && phase_reg == 2'h0)
                            begin
                                state_reg <= SCRP_TX;
                                shift_reg <= rd_data;
                                drive_reg <= ~rd_data[7];
                                ptr_reg <= ptr_reg + 16'h0001;
                            end
                            else
                            begin
                                state_reg <= SCRP_RX;
                                drive_reg <= 1'b0;
                                if (phase_reg != 2'h3)
                                    phase_reg <= phase_reg + 2'h1;
                            end
                        end
                    end
                    SCRP_TX:
                    begin
                        if (scl_rise)
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        else if (scl_fall && bit_cnt_reg == 4'h8)
                        begin
                            state_reg <= SCRP_MACK;
                            drive_reg <= 1'b0;
                        end
                        else if (scl_fall)
                        begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            drive_reg <= ~shift_reg[6];
                        end
                    end
                    SCRP_MACK:
                    begin
                        if (scl_rise)
                            nack_reg <= sda_i;
                        else if (scl_fall && nack_reg)
                            state_reg <= SCRP_IDLE;
                        else if (scl_fall)
                        begin
                            state_reg <= SCRP_TX;
                            bit_cnt_reg <= 4'h0;
                            shift_reg <= rd_data;
                            drive_reg <= ~rd_data[7];
                            ptr_reg <= ptr_reg + 16'h0001;
                        end
                    end
                    default:
                    begin
                        state_reg <= SCRP_IDLE;
                        drive_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open-drain data line, only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oen_o = ~drive_reg;

    // ---------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------
    logic standby;
    logic [3:0] word_bits;
    logic [3:0] lane_en;
    logic [3:0] pb_sys_x2;
    logic [7:0] pa_pre;
    logic [7:0] pb_in;
    logic [7:0] pb_sys;
    logic [7:0] pb_rd;
    logic [7:0] pb_pump;

    assign standby = ~cfg_reg[SCRP_I_MODE][SCRP_B_STREAM];
    assign pa_pre = cfg_reg[SCRP_I_PA_PREDIV];
    assign pb_in = cfg_reg[SCRP_I_PB_IN];
    assign pb_sys = cfg_reg[SCRP_I_PB_SYS];
    assign pb_rd = cfg_reg[SCRP_I_PB_RAM_DAC];
    assign pb_pump = cfg_reg[SCRP_I_PB_PUMP];

    // word width, reserved code shows zero
    assign word_bits = (cfg_reg[SCRP_I_SER_CFG][1:0] == 2'h0) ? 4'h8 :
                       (cfg_reg[SCRP_I_SER_CFG][1:0] == 2'h1) ? 4'ha :
                       (cfg_reg[SCRP_I_SER_CFG][1:0] == 2'h2) ? 4'hc : 4'h0;

    // lane enables, undefined codes enable nothing
    assign lane_en = (cfg_reg[SCRP_I_LANE][7:4] == 4'h1) ? 4'h1 :
                     (cfg_reg[SCRP_I_LANE][7:4] == 4'h2) ? 4'h3 :
                     (cfg_reg[SCRP_I_LANE][7:4] == 4'h4) ? 4'hf : 4'h0;

    // pll b system divider in half steps
    assign pb_sys_x2 = (pb_sys[6:4] == 3'h7) ? 4'ha : 4'({1'b0, pb_sys[6:4]} + 4'h2);

    // ---------------------------------------------------------------
    // registered control outputs
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            streaming_o <= 1'b0;
            core_rst_n_o <= 1'b0;
            other_rst_n_o <= 1'b0;
            word_bits_o <= 4'h0;
            lane_en_o <= 4'h0;
            hs_tx_powerdown_o <= 1'b0;
            lp_rx_powerdown_o <= 1'b0;
            pll_a_skip_o <= 1'b0;
            pll_a_input_prediv_x2_o <= 5'h02;
            pll_a_extra_prediv_o <= 2'h1;
            pll_a_post_div_o <= 5'h01;
            pll_a_loop_mult_o <= 10'h000;
            pll_a_serial_clk_div_o <= 4'h4;
            pll_a_sys_prediv_o <= 3'h3;
            pll_a_sys_div_o <= 2'h1;
            pll_b_skip_o <= 1'b0;
            pll_b_input_prediv_x2_o <= 5'h02;
            pll_b_extra_prediv_o <= 2'h1;
            pll_b_sys_div_x2_o <= 4'h2;
            pll_b_sys_prediv_o <= 5'h01;
            pll_b_ram_clk_div_o <= 5'h01;
            pll_b_dac_clk_div_o <= 5'h01;
            pll_b_loop_mult_o <= 10'h000;
            pump_n_div_o <= 4'h2;
            pump_p_div_o <= 4'h2;
            pump_powerdown_o <= 1'b0;
            sysclk_from_b_o <= 1'b0;
        end
        else
        begin
            streaming_o <= ~standby;
            core_rst_n_o <= ~standby;
            other_rst_n_o <= ~(standby & ~cfg_reg[SCRP_I_LOW_PWR][SCRP_B_STB_PART]);
            word_bits_o <= word_bits;
            lane_en_o <= lane_en;
            hs_tx_powerdown_o <= cfg_reg[SCRP_I_LANE][SCRP_B_HS_PD];
            lp_rx_powerdown_o <= cfg_reg[SCRP_I_LANE][SCRP_B_LP_PD];
            pll_a_skip_o <= cfg_reg[SCRP_I_PA_BYPASS][SCRP_B_PA_SKIP];
            pll_a_input_prediv_x2_o <= prediv_x2(pa_pre[2:0]);
            pll_a_extra_prediv_o <= cfg_reg[SCRP_I_PA_XPRE][SCRP_B_PA_XPRE] ? 2'h2 : 2'h1;
            pll_a_post_div_o <= {1'b0, cfg_reg[SCRP_I_PA_POST][3:0]} + 5'h01;
            pll_a_loop_mult_o <= {cfg_reg[SCRP_I_PA_MULT_HI][1:0], cfg_reg[SCRP_I_PA_MULT_LO]};
            pll_a_serial_clk_div_o <= (cfg_reg[SCRP_I_PA_SERIAL][1:0] == 2'h3) ? 4'h8 :
                                      4'({2'h0, cfg_reg[SCRP_I_PA_SERIAL][1:0]} + 4'h4);
            pll_a_sys_prediv_o <= 3'({1'b0, cfg_reg[SCRP_I_PA_SYS_PRE][1:0]} + 3'h3);
            pll_a_sys_div_o <= cfg_reg[SCRP_I_PA_SYS][SCRP_B_PA_SYS] ? 2'h2 : 2'h1;
            pll_b_skip_o <= pb_in[SCRP_B_PB_SKIP];
            pll_b_input_prediv_x2_o <= prediv_x2(pb_in[2:0]);
            pll_b_extra_prediv_o <= pb_in[SCRP_B_PB_XPRE] ? 2'h2 : 2'h1;
            pll_b_sys_div_x2_o <= pb_sys_x2;
            pll_b_sys_prediv_o <= {1'b0, pb_sys[3:0]} + 5'h01;
            pll_b_ram_clk_div_o <= {1'b0, pb_rd[7:4]} + 5'h01;
            pll_b_dac_clk_div_o <= {1'b0, pb_rd[3:0]} + 5'h01;
            pll_b_loop_mult_o <= {pb_pump[1:0], cfg_reg[SCRP_I_PB_MULT_LO]};
            pump_n_div_o <= pump_div(pb_pump[5:4]);
            pump_p_div_o <= pump_div(pb_pump[3:2]);
            pump_powerdown_o <= pb_sys[SCRP_B_PUMP_PD];
            sysclk_from_b_o <= cfg_reg[SCRP_I_CLK_SEL][7:5] != 3'h0;
        end
    end

endmodule

// ### design/scrp_pkg.sv
// constants and types shared by the sensor clock, reset and pll control block
package scrp_pkg;

    // ---------------------------------------------------------------
    // writable register map
    // ---------------------------------------------------------------
    localparam int SCRP_NREG = 39;

    localparam logic [15:0] SCRP_ADDR [SCRP_NREG] = '{
        16'h0100, 16'h0300, 16'h0301, 16'h0302, 16'h0303, 16'h0304, 16'h0305,
        16'h0306, 16'h0308, 16'h0309, 16'h030a, 16'h3009, 16'h300c, 16'h300d,
        16'h300e, 16'h300f, 16'h3010, 16'h3011, 16'h3012, 16'h3013, 16'h3014,
        16'h3015, 16'h3016, 16'h3017, 16'h3018, 16'h3019, 16'h301a, 16'h301b,
        16'h301c, 16'h301d, 16'h301e, 16'h301f, 16'h3020, 16'h3610, 16'h3611,
        16'h3612, 16'h3613, 16'h3614, 16'h3615
    };

    localparam logic [7:0] SCRP_RST [SCRP_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h2a, 8'h00, 8'h03, 8'h01,
        8'h01, 8'h00, 8'h01, 8'h00, 8'h06, 8'h20, 8'h15,
        8'h00, 8'h11, 8'h00, 8'h74, 8'h41, 8'h00, 8'h00,
        8'h00, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hb4,
        8'h01, 8'h02, 8'h00, 8'h03, 8'h00, 8'h00, 8'h10,
        8'h23, 8'h33, 8'h28, 8'h1c
    };

    // indices into the map above
    localparam int SCRP_I_MODE = 0;
    localparam int SCRP_I_PA_PREDIV = 1;
    localparam int SCRP_I_PA_MULT_HI = 2;
    localparam int SCRP_I_PA_MULT_LO = 3;
    localparam int SCRP_I_PA_POST = 4;
    localparam int SCRP_I_PA_SERIAL = 5;
    localparam int SCRP_I_PA_SYS_PRE = 6;
    localparam int SCRP_I_PA_SYS = 7;
    localparam int SCRP_I_PA_BYPASS = 8;
    localparam int SCRP_I_PA_XPRE = 10;
    localparam int SCRP_I_BUS_ADDR = 12;
    localparam int SCRP_I_SER_CFG = 15;
    localparam int SCRP_I_LANE = 18;
    localparam int SCRP_I_CLK_SEL = 30;
    localparam int SCRP_I_LOW_PWR = 32;
    localparam int SCRP_I_PB_IN = 34;
    localparam int SCRP_I_PB_SYS = 35;
    localparam int SCRP_I_PB_RAM_DAC = 36;
    localparam int SCRP_I_PB_MULT_LO = 37;
    localparam int SCRP_I_PB_PUMP = 38;

    // ---------------------------------------------------------------
    // other addresses
    // ---------------------------------------------------------------
    localparam logic [15:0] SCRP_A_SOFT_RST = 16'h0103;
    localparam logic [15:0] SCRP_A_PART_HI = 16'h300a;
    localparam logic [15:0] SCRP_A_PART_LO = 16'h300b;
    localparam logic [15:0] SCRP_A_REV = 16'h302a;
    localparam logic [15:0] SCRP_A_PIN0 = 16'h303d;
    localparam logic [15:0] SCRP_A_PIN1 = 16'h303e;
    localparam logic [7:0] SCRP_DEV_ALT = 8'h6c;

    // ---------------------------------------------------------------
    // single-bit field positions
    // ---------------------------------------------------------------
    localparam int SCRP_B_STREAM = 0;
    localparam int SCRP_B_SOFT_RST = 0;
    localparam int SCRP_B_PA_SKIP = 0;
    localparam int SCRP_B_PA_SYS = 0;
    localparam int SCRP_B_PA_XPRE = 0;
    localparam int SCRP_B_HS_PD = 2;
    localparam int SCRP_B_LP_PD = 1;
    localparam int SCRP_B_STB_PART = 4;
    localparam int SCRP_B_PB_SKIP = 7;
    localparam int SCRP_B_PB_XPRE = 3;
    localparam int SCRP_B_PUMP_PD = 7;

    // serial bus slave states
    typedef enum logic [2:0] {
        SCRP_IDLE,
        SCRP_RX,
        SCRP_ACK,
        SCRP_TX,
        SCRP_MACK
    } scrp_state_t;

endpackage

// ### test/scrp_ctrl_sva.sv
// port assertions for the sensor clock, reset and pll control block
module scrp_ctrl_sva (
    // clock, reset and bus
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oen_o,
    // decoded outputs
    input wire logic streaming_o,
    input wire logic core_rst_n_o,
    input wire logic other_rst_n_o,
    input wire logic [3:0] word_bits_o,
    input wire logic [3:0] lane_en_o,
    input wire logic [4:0] pll_a_input_prediv_x2_o,
    input wire logic [3:0] pll_a_serial_clk_div_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // standby resets against the run state
    core_run_a: assert property (core_rst_n_o == streaming_o) else $error("core reset off run");
    other_run_a: assert property (core_rst_n_o |-> other_rst_n_o) else $error("other reset held");
    // decoded codes stay in their tables
    width_code_a: assert property (word_bits_o inside {4'h0, 4'h8, 4'ha, 4'hc}) else $error("bad width");
    lane_code_a: assert property (lane_en_o inside {4'h0, 4'h1, 4'h3, 4'hf}) else $error("bad lanes");
    prediv_code_a: assert property (pll_a_input_prediv_x2_o inside {[5'h02:5'h06], 5'h08, 5'h0c, 5'h10})
        else $error("bad prediv");
    serial_code_a: assert property (pll_a_serial_clk_div_o inside {[4'h4:4'h6], 4'h8})
        else $error("bad serial div");
    // data line moves only while the bus clock is low
    ack_edge_a: assert property ($changed(sda_oen_o) |-> !$past(scl_i)) else $error("sda moved, scl high");
    drive_low_a: assert property (sda_o == 1'b0) else $error("sda driven high");
    // main scenarios
    run_c: cover property ($rose(streaming_o));
    ack_c: cover property ($fell(sda_oen_o));
    part_c: cover property (other_rst_n_o && !core_rst_n_o);
endmodule

bind scrp_ctrl scrp_ctrl_sva chk (.*);

// ### test/scrp_ctrl_tb.sv
// self-checking bench for the sensor clock, reset and pll control block
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s %h %h", n, e, g); end end
module scrp_ctrl_tb import scrp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, resetn_i = 1'b0, scl_i, sda_i, sda_h, addr_select_pin_i = 1'b0, sda_o, sda_oen_o, ok;
    logic streaming_o, core_rst_n_o, other_rst_n_o, hs_tx_powerdown_o, lp_rx_powerdown_o, pll_a_skip_o;
    logic pll_b_skip_o, pump_powerdown_o, sysclk_from_b_o;
    logic [1:0] pll_a_extra_prediv_o, pll_a_sys_div_o, pll_b_extra_prediv_o;
    logic [2:0] pll_a_sys_prediv_o;
    logic [3:0] word_bits_o, lane_en_o, pll_a_serial_clk_div_o, pll_b_sys_div_x2_o, pump_n_div_o, pump_p_div_o;
    logic [4:0] pll_a_input_prediv_x2_o, pll_a_post_div_o, pll_b_input_prediv_x2_o, pll_b_sys_prediv_o;
    logic [4:0] pll_b_ram_clk_div_o, pll_b_dac_clk_div_o;
    logic [9:0] pll_a_loop_mult_o, pll_b_loop_mult_o;
    logic [7:0] pin_status0_i = 8'h00, pin_status1_i = 8'h3c, rv;
    int errors = 0, num_checks = 0;
    // part code value is arbitrary
    scrp_ctrl #(.PART_HI(8'h5a)) dut (.*);
    scrp_host host (.mclk_i(mclk_i), .sda_line_i(sda_i), .scl_o(scl_i), .sda_o(sda_h));
    assign sda_i = sda_oen_o ? sda_h : 1'b0;
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // every code of the pll a input pre-divider, pll b system divider and word width fields, and lane codes 0, 1, 2 and 4
    task automatic t_codes();
        logic [4:0] px [8] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10};
        logic [3:0] bx [8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha};
        logic [3:0] wb [4] = '{4'h8, 4'ha, 4'hc, 4'h0};
        logic [3:0] ln [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
        `CHK("wb", 4'ha, word_bits_o)
        `CHK("pump", 4'h8, pump_p_div_o)
        for (int i = 0; i < 8; i++)
        begin
            host.acc(8'h20, 16'h0300, 8'(i), rv, ok);
            host.acc(8'h20, 16'h3612, {1'b1, 3'(i), 4'hf}, rv, ok);
            `CHK("apre", px[i], pll_a_input_prediv_x2_o)
            `CHK("bdiv", bx[i], pll_b_sys_div_x2_o)
            `CHK("bpre", 5'h10, pll_b_sys_prediv_o)
            `CHK("pd", 1'b1, pump_powerdown_o)
        end
        for (int i = 0; i < 4; i++)
        begin
            host.acc(8'h20, 16'h300f, 8'(i), rv, ok);
            host.acc(8'h20, 16'h3012, {4'(i == 3 ? 4 : i), 4'h6}, rv, ok);
            `CHK("wb", wb[i], word_bits_o)
            `CHK("lanes", ln[i], lane_en_o)
            `CHK("hspd", 1'b1, hs_tx_powerdown_o)
            `CHK("lppd", 1'b1, lp_rx_powerdown_o)
        end
        $display("codes done");
    endtask
    // split multipliers, the pump n divider and the remaining divider fields
    task automatic t_fields();
        logic [15:0] fa [12] = '{16'h0301, 16'h0302, 16'h3615, 16'h3611, 16'h0303, 16'h0304, 16'h0305, 16'h0306,
                                 16'h030a, 16'h0308, 16'h3613, 16'h301e};
        logic [7:0] fd [12] = '{8'h03, 8'h55, 8'h2e, 8'h9d, 8'h0b, 8'h02, 8'h03, 8'h00, 8'h01, 8'h01, 8'h7c, 8'h20};
        for (int i = 0; i < 12; i++)
        begin
            host.acc(8'h20, fa[i], fd[i], rv, ok);
            `CHK("wack", 1'b1, ok)
        end
        `CHK("amul", 10'h355, pll_a_loop_mult_o)
        `CHK("bmul", 10'h228, pll_b_loop_mult_o)
        `CHK("pumpn", 4'h4, pump_n_div_o)
        `CHK("bskip", 1'b1, pll_b_skip_o)
        `CHK("bxpre", 2'h2, pll_b_extra_prediv_o)
        `CHK("bpre", 5'h08, pll_b_input_prediv_x2_o)
        `CHK("apost", 5'h0c, pll_a_post_div_o)
        `CHK("aser", 4'h6, pll_a_serial_clk_div_o)
        `CHK("asyspre", 3'h6, pll_a_sys_prediv_o)
        `CHK("asys", 2'h1, pll_a_sys_div_o)
        `CHK("axpre", 2'h2, pll_a_extra_prediv_o)
        `CHK("askip", 1'b1, pll_a_skip_o)
        `CHK("ram", 5'h08, pll_b_ram_clk_div_o)
        `CHK("dac", 5'h0d, pll_b_dac_clk_div_o)
        `CHK("sclk", 1'b1, sysclk_from_b_o)
        $display("fields done");
    endtask
    // standby resets, run bit, refused and read-only accesses
    task automatic t_bus();
        host.acc(8'h20, 16'h3020, 8'h10, rv, ok);
        `CHK("other", 1'b1, other_rst_n_o)
        `CHK("core", 1'b0, core_rst_n_o)
        host.acc(8'h20, 16'h0100, 8'h01, rv, ok);
        `CHK("run", 1'b1, streaming_o)
        host.acc(8'h42, 16'h0100, 8'h00, rv, ok);
        `CHK("ack", 1'b0, ok)
        `CHK("run", 1'b1, streaming_o)
        host.acc(8'h20, SCRP_A_PART_HI, 8'h00, rv, ok);
        host.acc(8'h21, SCRP_A_PART_HI, 8'h00, rv, ok);
        `CHK("part", 8'h5a, rv)
        addr_select_pin_i = 1'b1;
        host.acc(SCRP_DEV_ALT | 8'h01, SCRP_A_PIN1, 8'h00, rv, ok);
        `CHK("pins", 8'h3c, rv)
        host.acc(SCRP_DEV_ALT | 8'h01, 16'h0302, 8'h00, rv, ok);
        `CHK("rdback", 8'h55, rv)
        host.acc(SCRP_DEV_ALT, 16'h0103, 8'h01, rv, ok);
        `CHK("srst", 1'b0, streaming_o)
        `CHK("srst", 10'h02a, pll_a_loop_mult_o)
        $display("bus done");
    endtask
    initial
    begin
        repeat (100000) @(posedge mclk_i);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        t_codes();
        t_fields();
        t_bus();
        tally_and_finish();
    end
endmodule

// ### test/scrp_host.sv
// two-wire bus host model reaching the register file
module scrp_host (
    input wire logic mclk_i,
    input wire logic sda_line_i,
    output logic scl_o = 1'b1,
    output logic sda_o = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    // whole clocks, lines change after the falling edge
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // one bit: data set while clock low, line sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        tick(4);
        scl_o = 1'b1;
        tick(4);
        r = sda_line_i;
        scl_o = 1'b0;
        tick(1);
    endtask
    // start or repeated start, stop
    task automatic start();
        sda_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        sda_o = 1'b0;
        tick(2);
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        sda_o = 1'b1;
        tick(4);
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, a);
    endtask
    // write (dev bit0 low) or read one byte ended by nack; ok when all acked
    task automatic acc(input logic [7:0] dev, input logic [15:0] ra, input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
        logic [3:0] k;
        logic [7:0] x;
        start();
        xfer(dev & 8'hfe, x, k[0]);
        xfer(ra[15:8], x, k[1]);
        xfer(ra[7:0], x, k[2]);
        if (dev[0])
        begin
            start();
            xfer(dev, x, k[3]);
            xfer(8'hff, q, x[0]);
        end
        else
            xfer(d, x, k[3]);
        stop();
        ok = (k == 4'h0);
    endtask
endmodule
